// ---- core/sideband_pkg.sv ----
// Constants and types shared by the processor sideband signalling logic
package sideband_pkg;
   // Pin level that means asserted on every active-low sideband pin
   localparam logic PIN_ASSERTED   = 1'b0;
   localparam logic PIN_DEASSERTED = 1'b1;
   // Reset values
   localparam logic RST_IRQ_CTRL_ENABLE = 1'b1;
   localparam logic RST_PERF_STATE      = 1'b0;
   // Power states as seen by the sideband logic
   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_SLEEP,
      PWR_DEEP_SLEEP
   } pwr_state_e;
   // Debug clock copy pipe depth in clk cycles; the output register adds one more
   localparam int  DBG_CLK_DELAY = 2;
   // Local interrupt line indices
   localparam int  LINE_MASKABLE    = 0;
   localparam int  LINE_NONMASKABLE = 1;
endpackage

// ---- core/pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_synced;

   // No reset here: a strap pin must still be seen live as reset ends
   always_comb
   begin
      next_meta   = async;
      next_synced = meta;
   end

   always_ff @(posedge clk)
   begin
      meta   <= next_meta;
      synced <= next_synced;
   end
endmodule
`default_nettype wire

// ---- core/cpu_sideband.sv ----
// Processor sideband signalling: error/break, perf select, snoop stall, init, irq pins
//
// Behaviour
// [R1] Unmasked FP error drives error/break when running
// [R2] Under stop-clock the pin flags pending break
// [R3] Pending break held until stop-clock released
// [R4] Controller withdraws stop-clock on pending break
// [R5] Perf select latched at Sleep, seen in Deep
// [R6] Perf select ignored outside Deep Sleep
// [R7] Hit plus hit-modified together request snoop stall
// [R8] Internal error held until next reset
// [R9] Internal error requests a halt bus cycle
// [R10] Ignore-numeric-error active: pending errors ignored
// [R11] Ignore inactive: earlier error raises exception
// [R12] Native numeric-error bit disables ignore input
// [R13] Ignore input valid during target-ready phase
// [R14] Soft init clears integer state, restarts
// [R15] Snoops still serviced during soft init
// [R16] Soft init at reset release runs self-test
// [R17] Debug clock pair is delayed bus clock copy
// [R18] Controller off: line0 maskable, line1 nonmaskable
// [R19] Local irq controller enabled after reset
// [R20] All sideband pins are active low; the bus clock input, the output enables and the debug clock pair are not
`timescale 1ns/100ps
`default_nettype none
module cpu_sideband
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Pins from the system (active low except the bus clock, asynchronous)
   input  wire logic                    stop_clock_request_n,
   input  wire logic                    perf_state_select_n,
   input  wire logic                    ignore_numeric_error_n,
   input  wire logic                    soft_init_n,
   input  wire logic [1:0]              local_irq_lines_n,
   input  wire logic                    snoop_hit_in_n,
   input  wire logic                    snoop_hit_modified_in_n,
   input  wire logic                    bus_clock_p,
   // Core-side events and state
   input  wire logic                    fp_error_unmasked,
   input  wire logic                    fp_error_pending,
   input  wire logic                    break_event,
   input  wire logic                    noncontrol_fp_instr,
   input  wire logic                    native_numeric_error_bit,
   input  wire logic                    internal_error,
   input  wire logic                    irq_ctrl_disable,
   input  wire logic                    snoop_stall_req,
   input  wire logic                    snoop_hit_req,
   input  wire logic                    snoop_snoop_hit_modified_req,
   input  wire sideband_pkg::pwr_state_e pwr_state,
   // Pins to the system (active low, except the output enables and the debug clock pair)
   output logic                         fp_error_break_pending_n,
   output logic                         internal_error_out_n,
   output logic                         snoop_hit_out_n,
   output logic                         snoop_hit_modified_out_n,
   output logic                         snoop_hit_oe,
   output logic                         snoop_hit_modified_oe,
   output logic [1:0]                   debug_clock_copy_out,
   // Core-side results
   output logic                         halt_bus_cycle,
   output logic                         fp_exception,
   output logic                         fp_continue,
   output logic                         int_reg_clear,
   output logic                         restart_at_vector,
   output logic                         snoop_enable,
   output logic                         run_selftest,
   output logic                         perf_state,
   output logic                         snoop_stall_seen,
   output logic                         maskable_irq,
   output logic                         nonmaskable_irq,
   output logic [1:0]                   local_irq_event,
   output logic                         irq_ctrl_enabled
);
   import sideband_pkg::*;
   // ==================================================
   // Input synchronisers
   logic [7:0] pinSync;
   logic       stopClk;
   logic       perfSel;
   logic       ignoreNe;
   logic       initAct;
   logic [1:0] irqLine;
   logic       hitIn;
   logic       hitmIn;
   logic       bclk;

   pin_sync #(.WIDTH(9)) u_sync
   (
      .clk    (clk),
      .async  ({bus_clock_p, stop_clock_request_n, perf_state_select_n,
                ignore_numeric_error_n, soft_init_n, local_irq_lines_n,
                snoop_hit_in_n, snoop_hit_modified_in_n}),
      .synced ({bclk, pinSync})
   );

   // Asserted means pin low
   assign stopClk  = (pinSync[7] == PIN_ASSERTED);                 // R20
   assign perfSel  = (pinSync[6] == PIN_ASSERTED);
   assign ignoreNe = (pinSync[5] == PIN_ASSERTED);
   assign initAct  = (pinSync[4] == PIN_ASSERTED);
   assign irqLine  = ~pinSync[3:2];
   assign hitIn    = (pinSync[1] == PIN_ASSERTED);
   assign hitmIn   = (pinSync[0] == PIN_ASSERTED);

   // ==================================================
   // Error/break pin, internal error, numeric error
   logic breakHeld;
   logic next_breakHeld;
   logic next_ferrN;
   logic ierrHeld;
   logic next_ierrHeld;
   logic next_ierrN;
   logic next_halt;
   logic next_fpExc;
   logic next_fpCont;
   logic ignoreEff;

   always_comb
   begin
      // Native error mode makes the ignore input meaningless
      ignoreEff      = ignoreNe && !native_numeric_error_bit;             // R12
      next_breakHeld = breakHeld;
      if (!stopClk)
         next_breakHeld = 1'b0;                                            // R3
      else if (break_event)
         next_breakHeld = 1'b1;                                            // R2
      if (stopClk)
         next_ferrN = next_breakHeld ? PIN_ASSERTED : PIN_DEASSERTED;      // R2
      else
         next_ferrN = fp_error_unmasked ? PIN_ASSERTED : PIN_DEASSERTED;   // R1
      next_ierrHeld = ierrHeld || internal_error;                          // R8
      next_ierrN    = next_ierrHeld ? PIN_ASSERTED : PIN_DEASSERTED;
      next_halt     = internal_error && !ierrHeld;                         // R9
      next_fpExc    = noncontrol_fp_instr && fp_error_pending && !ignoreEff; // R11
      next_fpCont   = noncontrol_fp_instr && (!fp_error_pending || ignoreEff); // R10
      if (rst)
      begin
         next_breakHeld = 1'b0;
         next_ferrN     = PIN_DEASSERTED;
         next_ierrHeld  = 1'b0;
         next_ierrN     = PIN_DEASSERTED;
         next_halt      = 1'b0;
         next_fpExc     = 1'b0;
         next_fpCont    = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      breakHeld                <= next_breakHeld;
      fp_error_break_pending_n <= next_ferrN;
      ierrHeld                 <= next_ierrHeld;
      internal_error_out_n     <= next_ierrN;
      halt_bus_cycle           <= next_halt;
      fp_exception             <= next_fpExc;
      fp_continue              <= next_fpCont;
   end

   // ==================================================
   // Soft init, self-test strap and performance select
   logic inResetPrev;
   logic next_inResetPrev;
   logic next_intClr;
   logic next_restart;
   logic next_snoopEn;
   logic next_selftest;
   logic initPrev;
   logic next_initPrev;
   logic perfLatched;
   logic next_perfLatched;
   logic next_perfState;
   pwr_state_e pwrPrev;
   pwr_state_e next_pwrPrev;

   always_comb
   begin
      next_inResetPrev = rst;
      next_initPrev    = initAct;
      next_intClr      = initAct;                                          // R14
      next_restart     = initPrev && !initAct;                             // R14
      next_snoopEn     = 1'b1;                                             // R15
      // Strap caught by the clocked edge just after reset falls
      next_selftest    = run_selftest;
      if (inResetPrev && !rst)
         next_selftest = initAct;                                          // R16
      next_pwrPrev     = pwr_state;
      next_perfLatched = perfLatched;
      if (pwr_state == PWR_SLEEP && pwrPrev != PWR_SLEEP)
         next_perfLatched = perfSel;                                       // R5
      next_perfState   = perf_state;
      if (pwr_state == PWR_DEEP_SLEEP)
         next_perfState = perfLatched && perfSel;                          // R5 R6
      if (rst)
      begin
         next_initPrev    = 1'b0;
         next_intClr      = 1'b0;
         next_restart     = 1'b0;
         next_snoopEn     = 1'b1;
         next_selftest    = 1'b0;
         next_pwrPrev     = PWR_NORMAL;
         next_perfLatched = RST_PERF_STATE;
         next_perfState   = RST_PERF_STATE;
      end
   end

   always_ff @(posedge clk)
   begin
      inResetPrev       <= next_inResetPrev;
      initPrev          <= next_initPrev;
      int_reg_clear     <= next_intClr;
      restart_at_vector <= next_restart;
      snoop_enable      <= next_snoopEn;
      run_selftest      <= next_selftest;
      pwrPrev           <= next_pwrPrev;
      perfLatched       <= next_perfLatched;
      perf_state        <= next_perfState;
   end

   // ==================================================
   // Snoop result pins, open drain
   logic next_hitN;
   logic next_hitmN;
   logic next_hitOe;
   logic next_hitmOe;
   logic next_stallSeen;

   always_comb
   begin
      // A stall drives both lines together; extended by repeating it
      next_hitOe     = snoop_stall_req || snoop_hit_req;                   // R7
      next_hitmOe    = snoop_stall_req || snoop_snoop_hit_modified_req;                  // R7
      next_hitN      = PIN_ASSERTED;
      next_hitmN     = PIN_ASSERTED;
      next_stallSeen = hitIn && hitmIn;                                    // R7
      if (rst)
      begin
         next_hitOe     = 1'b0;
         next_hitmOe    = 1'b0;
         next_stallSeen = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      snoop_hit_out_n          <= next_hitN;
      snoop_hit_modified_out_n <= next_hitmN;
      snoop_hit_oe             <= next_hitOe;
      snoop_hit_modified_oe    <= next_hitmOe;
      snoop_stall_seen         <= next_stallSeen;
   end

   // ==================================================
   // Debug clock copy, uncompensated and delayed
   logic [DBG_CLK_DELAY-1:0] clkPipe;
   logic [DBG_CLK_DELAY-1:0] next_clkPipe;
   logic [1:0]               next_dbgClk;

   always_comb
   begin
      next_clkPipe = {clkPipe[DBG_CLK_DELAY-2:0], bclk};
      next_dbgClk  = {~clkPipe[DBG_CLK_DELAY-1], clkPipe[DBG_CLK_DELAY-1]}; // R17
      if (rst)
      begin
         next_clkPipe = '0;
         next_dbgClk  = 2'h2;
      end
   end

   always_ff @(posedge clk)
   begin
      clkPipe              <= next_clkPipe;
      debug_clock_copy_out <= next_dbgClk;
   end

   // ==================================================
   // Local interrupt lines
   logic       next_mirq;
   logic       next_nmirq;
   logic [1:0] next_lirq;
   logic       next_ctrlEn;

   always_comb
   begin
      next_ctrlEn = !irq_ctrl_disable;
      next_mirq   = !irq_ctrl_enabled && irqLine[LINE_MASKABLE];            // R18
      next_nmirq  = !irq_ctrl_enabled && irqLine[LINE_NONMASKABLE];         // R18
      next_lirq   = irq_ctrl_enabled ? irqLine : 2'h0;
      if (rst)
      begin
         next_ctrlEn = RST_IRQ_CTRL_ENABLE;                                // R19
         next_mirq   = 1'b0;
         next_nmirq  = 1'b0;
         next_lirq   = 2'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      irq_ctrl_enabled <= next_ctrlEn;
      maskable_irq     <= next_mirq;
      nonmaskable_irq  <= next_nmirq;
      local_irq_event  <= next_lirq;
   end

   // ==================================================
   // Checks
   a_break_held_stop: assert property (@(posedge clk) disable iff (rst) // R3
      (stopClk && breakHeld && $past(stopClk)) |=> breakHeld)
      else $error("break indication dropped under stop-clock");
   a_fp_error_drive: assert property (@(posedge clk) disable iff (rst) // R1
      (!stopClk && fp_error_unmasked) |=> (fp_error_break_pending_n == 1'b0))
      else $error("fp error not driven");
   a_break_pin_drive: assert property (@(posedge clk) disable iff (rst) // R2
      (stopClk && break_event) |=> (fp_error_break_pending_n == 1'b0))
      else $error("pending break not driven");
   a_internal_error_out_sticky: assert property (@(posedge clk) disable iff (rst) // R8
      (internal_error_out_n == 1'b0) |=> (internal_error_out_n == 1'b0))
      else $error("internal error released before reset");
   a_internal_error_out_halt: assert property (@(posedge clk) disable iff (rst) // R9
      $rose(ierrHeld) |-> halt_bus_cycle)
      else $error("no halt cycle with internal error");
   a_ignore_native: assert property (@(posedge clk) disable iff (rst) // R12
      (native_numeric_error_bit && noncontrol_fp_instr && fp_error_pending)
      |=> fp_exception)
      else $error("ignore input acted in native mode");
   a_ignore_cont: assert property (@(posedge clk) disable iff (rst) // R10
      (ignoreNe && !native_numeric_error_bit && noncontrol_fp_instr) |=> !fp_exception)
      else $error("exception while ignoring");
   a_perf_outside: assert property (@(posedge clk) disable iff (rst) // R6
      (pwr_state != PWR_DEEP_SLEEP) |=> $stable(perf_state))
      else $error("perf state changed outside deep sleep");
   a_snoop_init: assert property (@(posedge clk) disable iff (rst) // R15
      initAct |=> snoop_enable)
      else $error("snoops stopped during init");
   a_irq_remap: assert property (@(posedge clk) disable iff (rst) // R18
      (!irq_ctrl_enabled && irqLine[LINE_NONMASKABLE]) |=> nonmaskable_irq)
      else $error("line 1 not routed as nonmaskable");
endmodule
`default_nettype wire

// ---- tb/sys_logic_model.sv ----
// Behavioural model of the system core logic facing the sideband pins
`timescale 1ns/100ps
`default_nettype none
module sys_logic_model
(
   input  wire logic       clk,
   input  wire logic       stopGo,
   input  wire logic [3:0] holdOff,
   input  wire logic [1:0] hitCmd,
   input  wire logic       pendingN,
   output logic            stopN,
   output logic            hitN,
   output logic            hitmN
);
   int waitCnt = 0;
   // ==========================================================
   // Stop-clock and snoop result pins
   // Updated by non-blocking assignment on the rising edge, so bench inputs never race it
   always @(posedge clk)
   begin
      hitN <= ~hitCmd[0];
      hitmN <= ~hitCmd[1];
      if (!stopGo)
      begin
         stopN <= 1'b1;
         waitCnt <= 0;
      end
      else if (pendingN == 1'b0 && stopN == 1'b0)
      begin
         // Service time is adjustable so both prompt and slow wake-ups get exercised
         if (waitCnt >= int'(holdOff))
            stopN <= 1'b1;
         waitCnt <= waitCnt + 1;
      end
      else if (waitCnt == 0)
         stopN <= 1'b0;
   end
endmodule
`default_nettype wire

// ---- tb/cpu_sideband_bench.sv ----
// Self-checking testbench for the processor sideband signalling block
`timescale 1ns/100ps
`default_nettype none
module cpu_sideband_bench;
   import sideband_pkg::*;
   // ==========================================================
   // Signals, named after the ports so the block connects by name
   logic clk = 1'b0, rst, stop_clock_request_n, perf_state_select_n, ignore_numeric_error_n;
   logic soft_init_n, snoop_hit_in_n, snoop_hit_modified_in_n, bus_clock_p, fp_error_unmasked;
   logic fp_error_pending, break_event, noncontrol_fp_instr, native_numeric_error_bit;
   logic internal_error, irq_ctrl_disable, snoop_stall_req, snoop_hit_req, snoop_snoop_hit_modified_req;
   logic fp_error_break_pending_n, internal_error_out_n, snoop_hit_out_n, snoop_hit_oe;
   logic snoop_hit_modified_out_n, snoop_hit_modified_oe, halt_bus_cycle, fp_exception;
   logic fp_continue, int_reg_clear, restart_at_vector, snoop_enable, run_selftest;
   logic perf_state, snoop_stall_seen, maskable_irq, nonmaskable_irq, irq_ctrl_enabled;
   logic [1:0] local_irq_lines_n, debug_clock_copy_out, local_irq_event, hitCmd;
   pwr_state_e pwr_state;
   logic       stopGo;
   logic [3:0] holdOff;
   logic [15:0] outv;
   logic [7:0] cnt [4];
   logic [31:0] seed = 32'h0000B84A;
   typedef struct {byte id; logic [7:0] exp;} note_s;
   note_s notes[$];
   event due;
   int error_cnt = 0;
   int check_count = 0;

   cpu_sideband dut_u (.*);
   sys_logic_model far_u (.clk(clk), .stopGo(stopGo), .holdOff(holdOff), .hitCmd(hitCmd),
      .pendingN(fp_error_break_pending_n), .stopN(stop_clock_request_n),
      .hitN(snoop_hit_in_n), .hitmN(snoop_hit_modified_in_n));

   always #50 clk = ~clk;
   assign outv = {snoop_enable, int_reg_clear, debug_clock_copy_out, local_irq_event,
      nonmaskable_irq, maskable_irq, snoop_hit_modified_oe, snoop_hit_oe, snoop_stall_seen,
      perf_state, run_selftest, irq_ctrl_enabled, internal_error_out_n, fp_error_break_pending_n};

   // ==========================================================
   // Pulse counters, so one-cycle results are never missed
   always @(posedge clk)
   begin
      if (rst)
         cnt <= '{default: 8'h00};
      else
      begin
         cnt[0] <= cnt[0] + {7'h00, halt_bus_cycle === 1'b1};
         cnt[1] <= cnt[1] + {7'h00, fp_exception === 1'b1};
         cnt[2] <= cnt[2] + {7'h00, fp_continue === 1'b1};
         cnt[3] <= cnt[3] + {7'h00, restart_at_vector === 1'b1};
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] obs(byte id);
      if (id < 16)
         return {7'h00, outv[id[3:0]]};
      if (id < 20)
         return cnt[id[1:0]];
      return {7'h00, id[0] ? snoop_hit_modified_out_n : snoop_hit_out_n};
   endfunction
   task automatic chk(byte id, logic [7:0] exp);
      notes.push_back('{id, exp});
      ->due;
   endtask
   task automatic wt(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Result watcher: oldest note against what the outputs show
   always @(due)
      while (notes.size() > 0)
      begin
         note_s n;
         n = notes.pop_front();
         check_count++;
         if (obs(n.id) !== n.exp)
         begin
            error_cnt++;
            $display("[ERR] %0t id %0d got %h want %h", $time, n.id, obs(n.id), n.exp);
         end
      end

   // ==========================================================
   // Stimulus
   initial
   begin
      logic [31:0] r;
      logic dq [40];
      logic [7:0] ec, cc;
      int k;
      rst = 1'b1;
      soft_init_n = 1'b0;
      {perf_state_select_n, ignore_numeric_error_n, bus_clock_p} = 3'h6;
      local_irq_lines_n = 2'h3;
      {fp_error_unmasked, fp_error_pending, break_event, noncontrol_fp_instr} = 4'h0;
      {native_numeric_error_bit, internal_error, irq_ctrl_disable} = 3'h0;
      {snoop_stall_req, snoop_hit_req, snoop_snoop_hit_modified_req} = 3'h0;
      pwr_state = PWR_NORMAL;
      {stopGo, holdOff, hitCmd} = 7'h00;
      wt(10);
      chk(0, 8'h01);
      chk(1, 8'h01);
      chk(2, 8'h01);
      wt(6);
      rst = 1'b0;
      wt(2);
      chk(3, 8'h01);
      chk(14, 8'h01);
      chk(15, 8'h01);
      soft_init_n = 1'b1;
      wt(5);
      chk(14, 8'h00);
      chk(19, 8'h01);
      fp_error_unmasked = 1'b1;
      wt(3);
      chk(0, 8'h00);
      fp_error_unmasked = 1'b0;
      wt(3);
      chk(0, 8'h01);
      // Pending break with a prompt and then a slow controller
      for (int j = 0; j < 2; j++)
      begin
         holdOff = (j == 0) ? 4'h1 : 4'h9;
         stopGo = 1'b1;
         wt(5);
         chk(0, 8'h01);
         break_event = 1'b1;
         wt(1);
         break_event = 1'b0;
         wt(2);
         chk(0, 8'h00);
         for (k = 0; k < 40 && stop_clock_request_n !== 1'b1; k++)
         begin
            chk(0, 8'h00);
            wt(1);
         end
         if (k == 40)
         begin
            error_cnt++;
            $display("[ERR] %0t stop-clock never withdrawn", $time);
            tally_and_finish();
         end
         wt(4);
         chk(0, 8'h01);
         stopGo = 1'b0;
         wt(2);
      end
      // Perf select: refused outside deep sleep, latched at sleep entry
      perf_state_select_n = 1'b0;
      wt(4);
      chk(4, {7'h00, RST_PERF_STATE});
      perf_state_select_n = 1'b1;
      wt(4);
      pwr_state = PWR_SLEEP;
      wt(4);
      pwr_state = PWR_DEEP_SLEEP;
      perf_state_select_n = 1'b0;
      wt(4);
      chk(4, 8'h00);
      pwr_state = PWR_NORMAL;
      wt(4);
      pwr_state = PWR_SLEEP;
      wt(4);
      pwr_state = PWR_DEEP_SLEEP;
      wt(4);
      chk(4, 8'h01);
      perf_state_select_n = 1'b1;
      wt(4);
      chk(4, 8'h00);
      pwr_state = PWR_NORMAL;
      perf_state_select_n = 1'b0;
      wt(4);
      chk(4, 8'h00);
      perf_state_select_n = 1'b1;
      // Snoop results and stall, random mixes
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         hitCmd = r[1:0];
         {snoop_stall_req, snoop_hit_req, snoop_snoop_hit_modified_req} = r[4:2];
         wt(4);
         chk(5, {7'h00, &r[1:0]});
         chk(6, {7'h00, r[4] | r[3]});
         chk(7, {7'h00, r[4] | r[2]});
         chk(20, 8'h00);
         chk(21, 8'h00);
      end
      // Numeric error handling, every combination of ignore pin and native bit
      {ec, cc} = 16'h0000;
      fp_error_pending = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         ignore_numeric_error_n = i[0];
         native_numeric_error_bit = i[1];
         wt(4);
         noncontrol_fp_instr = 1'b1;
         wt(1);
         noncontrol_fp_instr = 1'b0;
         wt(3);
         if (i == 0)
            cc++;
         else
            ec++;
         chk(17, ec);
         chk(18, cc);
      end
      // Internal error: held, one halt cycle, cleared only by reset
      for (int i = 0; i < 2; i++)
      begin
         internal_error = 1'b1;
         wt(1);
         internal_error = 1'b0;
         wt(20);
         chk(1, 8'h00);
         chk(16, 8'h01);
      end
      rst = 1'b1;
      wt(4);
      rst = 1'b0;
      wt(2);
      chk(1, 8'h01);
      chk(3, 8'h00);
      // Local interrupt lines in both controller modes
      for (int i = 0; i < 8; i++)
      begin
         irq_ctrl_disable = i[2];
         local_irq_lines_n = ~i[1:0];
         wt(4);
         chk(2, {7'h00, ~i[2]});
         chk(8, {7'h00, i[2] & i[0]});
         chk(9, {7'h00, i[2] & i[1]});
         chk(10, {7'h00, ~i[2] & i[0]});
         chk(11, {7'h00, ~i[2] & i[1]});
      end
      // Debug clock copy, random bus clock levels
      for (int i = 0; i < 40; i++)
      begin
         if (i >= 5)
         begin
            chk(12, {7'h00, dq[i-5]});
            chk(13, {7'h00, ~dq[i-5]});
         end
         r = rnd();
         dq[i] = r[0];
         bus_clock_p = r[0];
         wt(1);
      end
      wt(2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
